// ==== gpcp_defines.vh ====
// Register offsets, field codes and reset values of the 16-pin I/O port.
`ifndef GPCP_DEFINES_VH
`define GPCP_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define GPCP_OFS_MODE      8'h00
`define GPCP_OFS_OTYPE     8'h04
`define GPCP_OFS_SPEED0    8'h08
`define GPCP_OFS_PULL      8'h0C
`define GPCP_OFS_INPUT     8'h10
`define GPCP_OFS_OUTLVL    8'h14
`define GPCP_OFS_SETCLR    8'h18
`define GPCP_OFS_FREEZE    8'h1C
`define GPCP_OFS_AFSEL0    8'h20
`define GPCP_OFS_AFSEL1    8'h24
`define GPCP_OFS_CLRONLY   8'h28
`define GPCP_OFS_TOGGLE    8'h2C
`define GPCP_OFS_SPEED1    8'h3C

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GPCP_MODE_RST_A    32'h28000000
`define GPCP_SPEED0_RST_A  32'h0C000000
`define GPCP_PULL_RST_A    32'h24000000
`define GPCP_ZERO_RST      32'h00000000

// ----------------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------------
`define GPCP_MODE_INPUT    2'h0
`define GPCP_MODE_OUTPUT   2'h1
`define GPCP_MODE_ALT      2'h2
`define GPCP_MODE_ANALOG   2'h3
`define GPCP_PULL_UP       2'h1
`define GPCP_PULL_DOWN     2'h2
`define GPCP_SPEED_50M     2'h3
`define GPCP_FREEZE_KEY    16

`endif

// ==== gpcp_port.v ====
// Sixteen-pin general-purpose I/O port with an AHB-Lite register slave.
//
// Operation
// - Two-bit mode: input, output, alternate, analog.
// - Mode resets debug pins alternate on port A.
// - Output-type bit: push-pull or open-drain.
// - Alternate mode: selected peripheral of sixteen drives.
// - Alternate driver follows selected peripheral signal.
// - Additional function overrides port, then releases.
// - Owning unit sets pin type automatically.
// - Input: driver off, pad sampled every cycle.
// - Receiver stays on except in analog.
// - Pulls apply in input, output, alternate.
// - Open-drain: drive low or release.
// - Push-pull: drive low or high.
// - Output register reads back last written value.
// - Input register shows actual pad level.
// - Analog: pulls, driver, receiver off, reads zero.
// - Lock freezes configuration fields until reset.
// - Toggle write inverts output in one cycle.
// - Set/clear register sets low, clears high.
// - Pull field: floating, up, down, reserved.
// - Speed field: 2M, 10M, 50M.
`timescale 1ns/100ps
`include "gpcp_defines.vh"

module gpcp_port #(
    parameter PORT_A = 1,
    parameter NPIN   = 16,
    parameter NFUNC  = 16
) (
    input  wire                   sys_clk,
    input  wire                   resetn,
    input  wire                   hsel,
    input  wire [7:0]             haddr,
    input  wire [1:0]             htrans,
    input  wire                   hwrite,
    input  wire [2:0]             hsize,
    input  wire                   hready,
    input  wire [31:0]            hwdata,
    output wire [31:0]            hrdata,
    output wire                   hreadyout,
    output wire                   hresp,
    input  wire [NPIN-1:0]        pad_in,
    output wire [NPIN-1:0]        pad_out,
    output wire [NPIN-1:0]        pad_oe,
    output wire [NPIN-1:0]        pad_input_en,
    output wire [NPIN-1:0]        pad_pull_up,
    output wire [NPIN-1:0]        pad_pull_down,
    output wire [2*NPIN-1:0]      pad_speed,
    output wire [NPIN-1:0]        pad_very_high_speed,
    input  wire [NPIN*NFUNC-1:0]  af_out,
    input  wire [NPIN*NFUNC-1:0]  af_oe,
    output wire [NPIN-1:0]        af_in,
    input  wire [NPIN-1:0]        addf_en,
    input  wire [NPIN-1:0]        addf_out,
    input  wire [NPIN-1:0]        addf_oe,
    input  wire [NPIN-1:0]        addf_analog
);

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    reg  [31:0] mode_r, otype_r, speed0_r, pull_r, afsel0_r, afsel1_r, speed1_r;
    reg  [31:0] mode_nxt, otype_nxt, speed0_nxt, pull_nxt, afsel0_nxt, afsel1_nxt;
    reg  [31:0] speed1_nxt;
    reg  [15:0] outlvl_r;
    reg  [15:0] outlvl_nxt;
    reg  [15:0] input_r;
    reg  [15:0] sync1_r, sync2_r;
    reg  [15:0] frz_pins_r, frz_val_r;
    reg         frz_key_r;
    reg  [1:0]  frz_step_r;
    reg         wr_r;
    reg  [7:0]  addr_r;
    reg  [3:0]  be_r;
    reg  [3:0]  be_a;
    reg  [31:0] hrdata_r;
    reg  [31:0] rd_val;
    reg  [15:0] set_v, clr_v, tog_v;
    wire        acc_a;
    wire [31:0] wm;
    wire [31:0] lk2;
    wire [63:0] lk4;
    wire [31:0] wm2;
    wire [31:0] wm1;
    wire [31:0] wm4a;
    wire [31:0] wm4b;
    wire        wr_frz;
    wire [31:0] mode_rst;
    wire [31:0] speed0_rst;
    wire [31:0] pull_rst;

    assign mode_rst   = (PORT_A != 0) ? `GPCP_MODE_RST_A   : `GPCP_ZERO_RST;
    assign speed0_rst = (PORT_A != 0) ? `GPCP_SPEED0_RST_A : `GPCP_ZERO_RST;
    assign pull_rst   = (PORT_A != 0) ? `GPCP_PULL_RST_A   : `GPCP_ZERO_RST;

    assign acc_a     = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign wm        = {{8{be_r[3]}}, {8{be_r[2]}}, {8{be_r[1]}}, {8{be_r[0]}}};

    always @*
    begin
        case (hsize[1:0])
            2'h0:    be_a = 4'h1 << haddr[1:0];
            2'h1:    be_a = haddr[1] ? 4'hC : 4'h3;
            default: be_a = 4'hF;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            wr_r   <= 1'b0;
            addr_r <= 8'h00;
            be_r   <= 4'h0;
        end
        else
        begin
            wr_r   <= acc_a & hwrite;
            addr_r <= {haddr[7:2], 2'h0};
            be_r   <= be_a;
        end
    end

    // ------------------------------------------------------------------------
    // Lock masks per pin
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1)
        begin : g_lk
            assign lk2[2*gi+1:2*gi] = {2{frz_pins_r[gi]}};
            assign lk4[4*gi+3:4*gi] = {4{frz_pins_r[gi]}};
        end
    endgenerate

    // Only the locked pins lose their write lanes, the rest stay writable.
    assign wm2  = wm & ~lk2;
    assign wm1  = wm & {16'h0000, ~frz_pins_r};
    assign wm4a = wm & ~lk4[31:0];
    assign wm4b = wm & ~lk4[63:32];
    assign wr_frz = wr_r && (addr_r == `GPCP_OFS_FREEZE);

    always @*
    begin
        mode_nxt   = mode_r;
        otype_nxt  = otype_r;
        speed0_nxt = speed0_r;
        speed1_nxt = speed1_r;
        pull_nxt   = pull_r;
        afsel0_nxt = afsel0_r;
        afsel1_nxt = afsel1_r;
        outlvl_nxt = outlvl_r;
        set_v      = 16'h0000;
        clr_v      = 16'h0000;
        tog_v      = 16'h0000;
        if (wr_r)
        begin
            case (addr_r)
                `GPCP_OFS_MODE:    mode_nxt   = (mode_r & ~wm2) | (hwdata & wm2);
                `GPCP_OFS_OTYPE:   otype_nxt  = (otype_r & ~wm1) | (hwdata & wm1);
                `GPCP_OFS_SPEED0:  speed0_nxt = (speed0_r & ~wm2) | (hwdata & wm2);
                `GPCP_OFS_SPEED1:  speed1_nxt = (speed1_r & ~wm1) | (hwdata & wm1);
                `GPCP_OFS_PULL:    pull_nxt   = (pull_r & ~wm2) | (hwdata & wm2);
                `GPCP_OFS_AFSEL0:  afsel0_nxt = (afsel0_r & ~wm4a) | (hwdata & wm4a);
                `GPCP_OFS_AFSEL1:  afsel1_nxt = (afsel1_r & ~wm4b) | (hwdata & wm4b);
                `GPCP_OFS_OUTLVL:  outlvl_nxt = (outlvl_r & ~wm[15:0]) | (hwdata[15:0] & wm[15:0]);
                `GPCP_OFS_SETCLR:
                begin
                    set_v = hwdata[15:0] & wm[15:0];
                    clr_v = hwdata[31:16] & wm[31:16];
                end
                `GPCP_OFS_CLRONLY: clr_v = hwdata[15:0] & wm[15:0];
                `GPCP_OFS_TOGGLE:  tog_v = hwdata[15:0] & wm[15:0];
                default:           set_v = 16'h0000;
            endcase
        end
        // Set beats clear when both halves name the same pin.
        outlvl_nxt = ((outlvl_nxt & ~clr_v) | set_v) ^ tog_v;
    end

    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            mode_r   <= mode_rst;
            otype_r  <= `GPCP_ZERO_RST;
            speed0_r <= speed0_rst;
            speed1_r <= `GPCP_ZERO_RST;
            pull_r   <= pull_rst;
            afsel0_r <= `GPCP_ZERO_RST;
            afsel1_r <= `GPCP_ZERO_RST;
            outlvl_r <= 16'h0000;
        end
        else
        begin
            mode_r   <= mode_nxt;
            otype_r  <= {16'h0000, otype_nxt[15:0]};
            speed0_r <= speed0_nxt;
            speed1_r <= {16'h0000, speed1_nxt[15:0]};
            pull_r   <= pull_nxt;
            afsel0_r <= afsel0_nxt;
            afsel1_r <= afsel1_nxt;
            outlvl_r <= outlvl_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Lock key sequence: key 1, key 0, key 1 with equal pin bits
    // ------------------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            frz_pins_r <= 16'h0000;
            frz_val_r  <= 16'h0000;
            frz_key_r  <= 1'b0;
            frz_step_r <= 2'h0;
        end
        else if (wr_frz && !frz_key_r)
        begin
            frz_val_r <= hwdata[15:0];
            if (frz_step_r == 2'h0 && hwdata[`GPCP_FREEZE_KEY])
                frz_step_r <= 2'h1;
            else if (frz_step_r == 2'h1 && !hwdata[`GPCP_FREEZE_KEY]
                     && hwdata[15:0] == frz_val_r)
                frz_step_r <= 2'h2;
            else if (frz_step_r == 2'h2 && hwdata[`GPCP_FREEZE_KEY]
                     && hwdata[15:0] == frz_val_r)
            begin
                frz_step_r <= 2'h0;
                frz_key_r  <= 1'b1;
                frz_pins_r <= hwdata[15:0];
            end
            else
                frz_step_r <= hwdata[`GPCP_FREEZE_KEY] ? 2'h1 : 2'h0;
        end
    end

    // ------------------------------------------------------------------------
    // Read data, taken from next values so a read right after a write is fresh, except the freeze and input registers
    // ------------------------------------------------------------------------
    always @*
    begin
        case ({haddr[7:2], 2'h0})
            `GPCP_OFS_MODE:    rd_val = mode_nxt;
            `GPCP_OFS_OTYPE:   rd_val = {16'h0000, otype_nxt[15:0]};
            `GPCP_OFS_SPEED0:  rd_val = speed0_nxt;
            `GPCP_OFS_SPEED1:  rd_val = {16'h0000, speed1_nxt[15:0]};
            `GPCP_OFS_PULL:    rd_val = pull_nxt;
            `GPCP_OFS_INPUT:   rd_val = {16'h0000, input_r};
            `GPCP_OFS_OUTLVL:  rd_val = {16'h0000, outlvl_nxt};
            `GPCP_OFS_FREEZE:  rd_val = {15'h0000, frz_key_r, frz_pins_r};
            `GPCP_OFS_AFSEL0:  rd_val = afsel0_nxt;
            `GPCP_OFS_AFSEL1:  rd_val = afsel1_nxt;
            default:           rd_val = 32'h00000000;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (!resetn)
            hrdata_r <= 32'h00000000;
        else if (acc_a && !hwrite)
            hrdata_r <= rd_val;
    end

    // ------------------------------------------------------------------------
    // Pad sampling
    // ------------------------------------------------------------------------
    wire [NPIN-1:0] rx_on;

    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
            input_r <= 16'h0000;
        end
        else
        begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
            input_r <= sync2_r & rx_on;
        end
    end

    assign af_in = input_r;

    // ------------------------------------------------------------------------
    // Per-pin pad control
    // ------------------------------------------------------------------------
    reg [NPIN-1:0]   pout_r, poe_r, pie_r, ppu_r, ppd_r, pvh_r;
    reg [2*NPIN-1:0] pspd_r;
    wire [63:0]      afsel_all;

    assign afsel_all = {afsel1_r, afsel0_r};

    generate
        for (gi = 0; gi < NPIN; gi = gi + 1)
        begin : g_pin
            wire [1:0] md  = mode_r[2*gi+1:2*gi];
            wire [1:0] pl  = pull_r[2*gi+1:2*gi];
            wire [1:0] sp  = speed0_r[2*gi+1:2*gi];
            wire [3:0] fs  = afsel_all[4*gi+3:4*gi];
            wire       afo = af_out[gi*NFUNC + fs];
            wire       afe = af_oe[gi*NFUNC + fs];
            wire       ana = addf_en[gi] ? addf_analog[gi] : (md == `GPCP_MODE_ANALOG);
            wire       src = (md == `GPCP_MODE_ALT) ? afo : outlvl_r[gi];
            wire       drv = (md == `GPCP_MODE_OUTPUT) | ((md == `GPCP_MODE_ALT) & afe);
            wire       od  = otype_r[gi];

            assign rx_on[gi] = ~ana;

            always @(posedge sys_clk)
            begin
                if (!resetn)
                begin
                    pout_r[gi] <= 1'b0;
                    poe_r[gi]  <= 1'b0;
                    pie_r[gi]  <= 1'b0;
                    ppu_r[gi]  <= 1'b0;
                    ppd_r[gi]  <= 1'b0;
                    pvh_r[gi]  <= 1'b0;
                    pspd_r[2*gi+1:2*gi] <= 2'h0;
                end
                else if (addf_en[gi])
                begin
                    // The owning unit decides level, drive and analog; pulls and very high speed are off, speed stays from the speed field.
                    pout_r[gi] <= addf_out[gi];
                    poe_r[gi]  <= addf_oe[gi] & ~addf_analog[gi];
                    pie_r[gi]  <= ~addf_analog[gi];
                    ppu_r[gi]  <= 1'b0;
                    ppd_r[gi]  <= 1'b0;
                    pvh_r[gi]  <= 1'b0;
                    pspd_r[2*gi+1:2*gi] <= sp;
                end
                else
                begin
                    pout_r[gi] <= od ? 1'b0 : src;
                    poe_r[gi]  <= drv & ~ana & (~od | ~src);
                    pie_r[gi]  <= ~ana;
                    ppu_r[gi]  <= ~ana & (pl == `GPCP_PULL_UP);
                    ppd_r[gi]  <= ~ana & (pl == `GPCP_PULL_DOWN);
                    pvh_r[gi]  <= speed1_r[gi] & (sp == `GPCP_SPEED_50M);
                    pspd_r[2*gi+1:2*gi] <= sp;
                end
            end
        end
    endgenerate

    assign pad_out             = pout_r;
    assign pad_oe              = poe_r;
    assign pad_input_en        = pie_r;
    assign pad_pull_up         = ppu_r;
    assign pad_pull_down       = ppd_r;
    assign pad_speed           = pspd_r;
    assign pad_very_high_speed = pvh_r;

endmodule

// ==== gpcp_port_chk.sv ====
// Port-level assertions for the sixteen-pin I/O port.
`timescale 1ns/100ps
`include "gpcp_defines.vh"
module gpcp_port_chk #(
    parameter PORT_A = 1,
    parameter NPIN   = 16,
    parameter NFUNC  = 16
) (
    input wire logic              sys_clk,
    input wire logic              resetn,
    input wire logic              hsel,
    input wire logic [7:0]        haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic [NPIN-1:0]   pad_in,
    input wire logic [NPIN-1:0]   pad_oe,
    input wire logic [NPIN-1:0]   pad_input_en,
    input wire logic [NPIN-1:0]   pad_pull_up,
    input wire logic [NPIN-1:0]   pad_pull_down,
    input wire logic [2*NPIN-1:0] pad_speed,
    input wire logic [NPIN-1:0]   pad_very_high_speed,
    input wire logic [NPIN-1:0]   af_in
);
    // ----
    // Data-phase tracking
    // ----
    logic          rd_r;
    logic          rd_in_r;
    logic [15:0]   sp11;
    wire           rd_a = hsel && htrans[1] && hready && !hwrite;
    always @(posedge sys_clk)
    begin
        rd_r    <= resetn && rd_a;
        rd_in_r <= resetn && rd_a && haddr == `GPCP_OFS_INPUT;
    end
    genvar i;
    for (i = 0; i < 16; i = i + 1)
    begin : g_sp
        assign sp11[i] = &pad_speed[2*i+1:2*i];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_reset_pads;
        $rose(resetn) |=> pad_pull_up == 16'h2000 && pad_pull_down == 16'h4000
            && pad_speed == 32'h0C000000 && (pad_oe & 16'h9FFF) == 16'h0000
            && pad_input_en == 16'hFFFF;
    endproperty
    a_reset_pads: assert property (p_reset_pads) else $error("pad state after reset wrong");
    property p_pull_excl;
        (pad_pull_up & pad_pull_down) == 16'h0000;
    endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("pull up and down together");
    property p_analog_off;
        (~pad_input_en & (pad_pull_up | pad_pull_down | pad_oe)) == 16'h0000;
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog pin not quiet");
    property p_analog_zero;
        (~pad_input_en & ~$past(pad_input_en) & ~$past(pad_input_en, 2)
            & ~$past(pad_input_en, 3) & af_in) == 16'h0000;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog input not zero");
    property p_vhs;
        (pad_very_high_speed & ~sp11) == 16'h0000;
    endproperty
    a_vhs: assert property (p_vhs) else $error("very high speed without 50M field");
    property p_input_track;
        (&pad_input_en && $stable(pad_in))[*5] |-> af_in == pad_in;
    endproperty
    a_input_track: assert property (p_input_track) else $error("input status lags pad");
    property p_input_read;
        (&pad_input_en && $stable(pad_in))[*5] ##0 rd_in_r |-> hrdata == {16'h0000, pad_in};
    endproperty
    a_input_read: assert property (p_input_read) else $error("input read not pad level");
    property p_hrdata_hold;
        !rd_r |-> $stable(hrdata);
    endproperty
    a_hrdata_hold: assert property (p_hrdata_hold) else $error("read data moved");
endmodule
bind gpcp_port gpcp_port_chk #(.PORT_A(PORT_A), .NPIN(NPIN), .NFUNC(NFUNC)) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .pad_in(pad_in), .pad_oe(pad_oe),
    .pad_input_en(pad_input_en), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
    .pad_speed(pad_speed), .pad_very_high_speed(pad_very_high_speed), .af_in(af_in));

// ==== gpcp_pad_model.sv ====
// Pads and peripheral functions on the far side of the I/O port.
`timescale 1ns/100ps
module gpcp_pad_model (
    input  wire logic           sys_clk,
    input  wire logic [15:0]    pad_out,
    input  wire logic [15:0]    pad_oe,
    input  wire logic [15:0]    pad_pull_up,
    input  wire logic [15:0]    pad_pull_down,
    input  wire logic [15:0]    ext_en,
    input  wire logic [15:0]    ext_val,
    input  wire logic [15:0]    af_val,
    output logic [15:0]         pad_in,
    output logic [255:0]        af_out,
    output logic [255:0]        af_oe
);
    // An undriven unpulled pad wanders, so a stale level never reads as valid.
    logic [15:0] float_r = 16'h0000;
    always @(posedge sys_clk)
        float_r <= ~float_r;
    always_comb
    begin
        for (int p = 0; p < 16; p++)
        begin
            for (int f = 0; f < 16; f++)
            begin
                af_out[p*16+f] = af_val[p] ^ (f % 2 == 1);
                af_oe[p*16+f]  = (f != 15);
            end
            pad_in[p] = pad_oe[p] ? pad_out[p] : ext_en[p] ? ext_val[p] :
                        pad_pull_up[p] ? 1'b1 : pad_pull_down[p] ? 1'b0 : float_r[p];
        end
    end
endmodule

// ==== gpcp_port_tb.sv ====
// Self-checking testbench of the sixteen-pin I/O port.
`timescale 1ns/100ps
`include "gpcp_defines.vh"
module gpcp_port_tb;
    logic          sys_clk = 1'b0;
    logic          resetn = 1'b0;
    logic          hsel = 1'b0;
    logic          hwrite = 1'b0;
    logic [7:0]    haddr = 8'h00;
    logic [1:0]    htrans = 2'h0;
    logic [31:0]   hwdata = 32'h0;
    logic [15:0]   addf_en = 16'h0, addf_out = 16'h0, addf_oe = 16'h0;
    logic [15:0]   addf_ana = 16'h0;
    logic [2:0]    hsize = 3'h2;
    logic [15:0]   ext_en = 16'h9FFF, ext_val = 16'h0AB1, af_val = 16'h2020;
    wire  [31:0]   hrdata, pad_speed;
    wire           hreadyout, hresp;
    wire  [15:0]   pad_in, pad_out, pad_oe, pad_input_en, pad_pull_up, pad_pull_down;
    wire  [15:0]   vhs, af_in;
    wire  [255:0]  af_out, af_oe;
    logic [31:0]   d;
    int            miscompares = 0;
    int            cmp_count = 0;
    always #5 sys_clk = ~sys_clk;
    gpcp_port DUT (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(1'b1), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_input_en(pad_input_en),
        .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .pad_speed(pad_speed),
        .pad_very_high_speed(vhs), .af_out(af_out), .af_oe(af_oe), .af_in(af_in),
        .addf_en(addf_en), .addf_out(addf_out), .addf_oe(addf_oe), .addf_analog(addf_ana));
    gpcp_pad_model u_pads (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .ext_en(ext_en),
        .ext_val(ext_val), .af_val(af_val), .pad_in(pad_in), .af_out(af_out), .af_oe(af_oe));
    // ----
    // Bus and compare helpers
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits one edge past the data phase so the pads have settled.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, 1'b1, a};
        @(posedge sys_clk);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, v};
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, 1'b0, a};
        @(posedge sys_clk);
        {hsel, htrans} <= 3'h0;
        @(posedge sys_clk);
        d = hrdata;
        #1;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        rc(`GPCP_OFS_MODE, `GPCP_MODE_RST_A);
        rc(`GPCP_OFS_OTYPE, 32'h0);
        rc(`GPCP_OFS_SPEED0, `GPCP_SPEED0_RST_A);
        rc(`GPCP_OFS_PULL, `GPCP_PULL_RST_A);
        chk({pad_oe, pad_out} & 32'h60006000, 32'h60002000);
        chk({pad_input_en, pad_pull_up}, 32'hFFFF2000);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        wr(8'h30, 32'hFFFFFFFF);
        rc(8'h30, 32'h0);
    endtask
    task automatic t_output;
        wr(`GPCP_OFS_MODE, 32'h28000055);
        wr(`GPCP_OFS_OTYPE, 32'hFFFF0003);
        rc(`GPCP_OFS_OTYPE, 32'h3);
        wr(`GPCP_OFS_OUTLVL, 32'h5);
        rc(`GPCP_OFS_OUTLVL, 32'h5);
        chk({12'h0, pad_oe[3:0], 12'h0, pad_out[3:0]}, 32'h000E0004);
        repeat (5) @(posedge sys_clk);
        rd(`GPCP_OFS_INPUT);
        chk(d & 32'h1FFF, {16'h0, ext_val & 16'h1FF0} | 32'h5);
    endtask
    task automatic t_bitops;
        wr(`GPCP_OFS_SETCLR, 32'h00020008);
        rc(`GPCP_OFS_OUTLVL, 32'hD);
        wr(`GPCP_OFS_SETCLR, 32'h00020002);
        rc(`GPCP_OFS_OUTLVL, 32'hF);
        wr(`GPCP_OFS_CLRONLY, 32'h4);
        rc(`GPCP_OFS_OUTLVL, 32'hB);
        wr(`GPCP_OFS_TOGGLE, 32'h9);
        chk({12'h0, pad_oe[3:0], 12'h0, pad_out[3:0]}, 32'h000D0000);
        rc(`GPCP_OFS_OUTLVL, 32'h2);
        // A byte write must touch its own lane only, whatever the other lanes carry.
        @(posedge sys_clk);
        hsize <= 3'h0;
        wr(8'h15, 32'hFFFFFFFF);
        @(posedge sys_clk);
        hsize <= 3'h2;
        rc(`GPCP_OFS_OUTLVL, 32'hFF02);
    endtask
    task automatic t_speed;
        wr(`GPCP_OFS_SPEED1, 32'h1);
        chk({16'h0, vhs}, 32'h0);
        wr(`GPCP_OFS_SPEED0, 32'h0C000003);
        chk({pad_speed[1:0], 14'h0, vhs}, 32'hC0000001);
        wr(`GPCP_OFS_SPEED0, 32'h0C000001);
        chk({pad_speed[1:0], 14'h0, vhs}, 32'h40000000);
    endtask
    task automatic t_analog;
        wr(`GPCP_OFS_PULL, 32'h24000100);
        wr(`GPCP_OFS_MODE, 32'h28000355);
        chk({29'h0, pad_input_en[4], pad_pull_up[4], pad_oe[4]}, 32'h0);
        rd(`GPCP_OFS_INPUT);
        chk(d & 32'h10, 32'h0);
        wr(`GPCP_OFS_MODE, 32'h28000055);
        chk({30'h0, pad_input_en[4], pad_pull_up[4]}, 32'h3);
    endtask
    task automatic t_altfn;
        wr(`GPCP_OFS_MODE, 32'h28000855);
        for (int f = 0; f < 16; f++)
        begin
            wr(`GPCP_OFS_AFSEL0, f << 20);
            chk({pad_oe[5], pad_out[5] & pad_oe[5]}, {f != 15, f != 15 && f % 2 == 0});
        end
        @(posedge sys_clk);
        {addf_en, addf_oe, addf_out} <= {3{16'h0040}};
        repeat (3) @(posedge sys_clk);
        #1;
        chk({pad_oe[6], pad_out[6]}, 32'h3);
        @(posedge sys_clk);
        addf_ana <= 16'h0040;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({pad_oe[6], pad_input_en[6]}, 32'h0);
        @(posedge sys_clk);
        {addf_en, addf_ana} <= 32'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({31'h0, pad_oe[6]}, 32'h0);
    endtask
    task automatic t_lock;
        wr(`GPCP_OFS_FREEZE, 32'h00010010);
        wr(`GPCP_OFS_FREEZE, 32'h00000010);
        wr(`GPCP_OFS_FREEZE, 32'h00010010);
        rc(`GPCP_OFS_FREEZE, 32'h00010010);
        wr(`GPCP_OFS_MODE, 32'h28000300);
        rc(`GPCP_OFS_MODE, 32'h28000000);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rc(`GPCP_OFS_FREEZE, 32'h0);
        wr(`GPCP_OFS_MODE, 32'h28000300);
        rc(`GPCP_OFS_MODE, 32'h28000300);
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_output();
        t_bitops();
        t_speed();
        t_analog();
        t_altfn();
        t_lock();
        give_verdict();
    end
    // The whole sequence needs a few hundred cycles; this is 20000 cycles, far more than that.
    initial
    begin
        #200000;
        miscompares++;
        give_verdict();
    end
endmodule
